// *** design/eep_dev.sv ***
`timescale 1ns/100ps
module eep_dev #(
    parameter int unsigned PROG_TICKS = eep_pkg::PROG_US
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Serial bus pins
    input wire logic cs_pin,
    input wire logic sck_pin,
    input wire logic din_pin,
    // Strap pins
    input wire logic wen_pin,
    input wire logic pren_pin,
    // Serial data out
    output logic dout,
    output logic dout_oe_n
);
    // ==================================================
    // Pin synchronisers
    logic [eep_pkg::PIN_COUNT-1:0] raw;
    logic [eep_pkg::PIN_COUNT-1:0] s1_r, s2_r, s3_r, lvl_r;
    eep_pkg::eep_pins_t p, prev_r;

    assign raw = {cs_pin, sck_pin, din_pin, wen_pin, pren_pin};
    assign p = eep_pkg::eep_pins_t'(lvl_r);

    for (genvar g = 0; g < eep_pkg::PIN_COUNT; g++) begin : g_sync
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                s1_r[g] <= 1'b0;
                s2_r[g] <= 1'b0;
                s3_r[g] <= 1'b0;
                lvl_r[g] <= 1'b0;
            end else begin
                s1_r[g] <= raw[g];
                s2_r[g] <= s1_r[g];
                s3_r[g] <= s2_r[g];
                // Glitch of one sample never reaches the decoder
                if (s2_r[g] == s3_r[g]) begin
                    lvl_r[g] <= s3_r[g];
                end
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prev_r <= '0;
        end else begin
            prev_r <= p;
        end
    end

    logic sck_rise, cs_fall;
    assign sck_rise = p.cs && p.sck && !prev_r.sck;
    assign cs_fall = prev_r.cs && !p.cs;

    // ==================================================
    // Frame parser
    eep_pkg::eep_state_t state_r;
    eep_pkg::eep_cmd_t cmd_r, dec_cmd;
    logic [4:0] cnt_r;
    logic [6:0] hdr_r;
    logic [14:0] dat_r;
    logic [5:0] base_r;
    logic [1:0] rxk_r;
    logic end_ok_r, busy_r, wd_vld_r, in_rdy, frame_start, hdr_done;
    eep_pkg::eep_word_t wd_r;
    logic [7:0] full;

    function automatic eep_pkg::eep_cmd_t decode(input logic pre, input logic [7:0] f);
        eep_pkg::eep_cmd_t c;
        c = eep_pkg::C_NONE;
        if (f[7:6] == eep_pkg::OP_READ) begin
            c = pre ? eep_pkg::C_PRREAD : eep_pkg::C_READ;
        end else if (f[7:6] == eep_pkg::OP_WRITE) begin
            c = pre ? eep_pkg::C_PRWRITE : eep_pkg::C_WRITE;
        end else if (f[7:6] == eep_pkg::OP_PAGE) begin
            c = !pre ? eep_pkg::C_PAGE
              : (f[5:0] == eep_pkg::ADDR_ONES) ? eep_pkg::C_PRCLEAR : eep_pkg::C_NONE;
        end else if (f[5:4] == eep_pkg::EX_WEN) begin
            c = pre ? eep_pkg::C_PREN : eep_pkg::C_WEN;
        end else if (f[5:4] == eep_pkg::EX_WRALL) begin
            c = pre ? eep_pkg::C_NONE : eep_pkg::C_WRALL;
        end else if (f[5:4] == eep_pkg::EX_WDS) begin
            c = !pre ? eep_pkg::C_WDS
              : (f[5:0] == eep_pkg::ADDR_ZERO) ? eep_pkg::C_PRDS : eep_pkg::C_NONE;
        end
        return c;
    endfunction : decode

    assign full = {hdr_r, p.din};
    assign dec_cmd = decode(p.pren, full);
    assign frame_start = sck_rise && !busy_r && state_r == eep_pkg::S_IDLE && p.din;
    assign hdr_done = sck_rise && !busy_r && state_r == eep_pkg::S_HDR && cnt_r == 5'h07;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= eep_pkg::S_IDLE;
            cmd_r <= eep_pkg::C_NONE;
            cnt_r <= '0;
            hdr_r <= '0;
            dat_r <= '0;
            base_r <= '0;
            rxk_r <= '0;
            end_ok_r <= 1'b0;
        end else if (!p.cs || busy_r) begin
            // Bus data is ignored for the whole programming cycle
            state_r <= eep_pkg::S_IDLE;
            end_ok_r <= 1'b0;
        end else if (sck_rise) begin
            unique case (state_r)
                eep_pkg::S_IDLE: begin
                    if (p.din) begin
                        state_r <= eep_pkg::S_HDR;
                        cnt_r <= '0;
                        rxk_r <= '0;
                    end
                end
                eep_pkg::S_HDR: begin
                    hdr_r <= full[6:0];
                    cnt_r <= cnt_r + 5'h01;
                    if (hdr_done) begin
                        cmd_r <= dec_cmd;
                        base_r <= full[5:0];
                        cnt_r <= '0;
                        end_ok_r <= dec_cmd != eep_pkg::C_NONE;
                        unique case (dec_cmd)
                            eep_pkg::C_READ, eep_pkg::C_PRREAD: state_r <= eep_pkg::S_READ;
                            eep_pkg::C_WRITE, eep_pkg::C_PAGE, eep_pkg::C_WRALL: begin
                                state_r <= eep_pkg::S_DATA;
                                end_ok_r <= 1'b0;
                            end
                            default: state_r <= eep_pkg::S_DONE;
                        endcase
                    end
                end
                eep_pkg::S_DATA: begin
                    dat_r <= {dat_r[13:0], p.din};
                    cnt_r <= cnt_r + 5'h01;
                    end_ok_r <= 1'b0;
                    if (cnt_r == 5'h0F) begin
                        cnt_r <= '0;
                        end_ok_r <= 1'b1;
                        rxk_r <= rxk_r + 2'h1;
                        if (cmd_r != eep_pkg::C_PAGE) begin
                            state_r <= eep_pkg::S_DONE;
                        end
                    end
                end
                eep_pkg::S_READ: state_r <= eep_pkg::S_READ;
                eep_pkg::S_DONE: end_ok_r <= 1'b0;
            endcase
        end
    end

    // Completed word waits here until the buffer takes it
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wd_vld_r <= 1'b0;
            wd_r <= '0;
        end else if (sck_rise && !busy_r && state_r == eep_pkg::S_DATA && cnt_r == 5'h0F) begin
            wd_vld_r <= 1'b1;
            wd_r <= '{addr: {base_r[5:2], base_r[1:0] + rxk_r}, data: {dat_r, p.din}};
        end else if (in_rdy) begin
            wd_vld_r <= 1'b0;
        end
    end

    // ==================================================
    // Word buffer and page latch
    logic out_vld;
    eep_pkg::eep_word_t out_w;
    logic [15:0] lat_r [eep_pkg::PAGE_WORDS];
    logic [3:0] vld_r;

    eep_buf #(.W($bits(eep_pkg::eep_word_t)), .DEPTH(eep_pkg::FIFO_DEPTH)) u_buf (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(wd_vld_r),
        .in_ready(in_rdy),
        .in_data(wd_r),
        .out_valid(out_vld),
        .out_ready(!busy_r),
        .out_data(out_w)
    );

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            vld_r <= '0;
            for (int k = 0; k < eep_pkg::PAGE_WORDS; k++) begin
                lat_r[k] <= '0;
            end
        end else begin
            if (frame_start) begin
                vld_r <= '0;
            end
            if (out_vld && !busy_r) begin
                // Low address bits wrap inside the page
                lat_r[out_w.addr[1:0]] <= out_w.data;
                vld_r[out_w.addr[1:0]] <= 1'b1;
            end
        end
    end

    // ==================================================
    // Protection and commit
    logic [5:0] prot_addr_r;
    logic prot_clr_r, lock_r, we_en_r, pr_en_r;
    logic [3:0] blk;
    logic wr_type, pr_type, commit;

    for (genvar k = 0; k < eep_pkg::PAGE_WORDS; k++) begin : g_blk
        assign blk[k] = vld_r[k] && !prot_clr_r
                      && {base_r[5:2], 2'(k)} >= prot_addr_r;
    end

    assign wr_type = cmd_r == eep_pkg::C_WRITE || cmd_r == eep_pkg::C_PAGE
                   || cmd_r == eep_pkg::C_WRALL;
    assign pr_type = cmd_r == eep_pkg::C_PRWRITE || cmd_r == eep_pkg::C_PRCLEAR
                   || cmd_r == eep_pkg::C_PRDS;
    // Frame must end exactly on its last bit; the low gap before the next frame is the host's
    assign commit = cs_fall && end_ok_r && !busy_r && !out_vld && !wd_vld_r && p.wen
                  && we_en_r && ((wr_type && blk == '0
                  && (cmd_r != eep_pkg::C_WRALL || prot_clr_r))
                  || (pr_type && pr_en_r && !lock_r));

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            we_en_r <= 1'b0;
            pr_en_r <= 1'b0;
        end else if (cs_fall && end_ok_r && !busy_r) begin
            if (cmd_r == eep_pkg::C_WEN && p.wen) begin
                we_en_r <= 1'b1;
            end else if (cmd_r == eep_pkg::C_WDS) begin
                we_en_r <= 1'b0;
            end else if (cmd_r == eep_pkg::C_PREN && p.wen) begin
                pr_en_r <= 1'b1;
            end
        end
    end

    // ==================================================
    // Self-timed programming
    eep_pkg::eep_cmd_t pmode_r;
    logic [5:0] paddr_r;
    logic [6:0] div_r;
    logic [23:0] us_r;
    logic tick, prog_done;

    assign tick = div_r == 7'(eep_pkg::TICK_CYC - 1);
    assign prog_done = busy_r && tick && us_r == 24'(PROG_TICKS - 1);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
            div_r <= '0;
            us_r <= '0;
            pmode_r <= eep_pkg::C_NONE;
            paddr_r <= '0;
        end else if (commit) begin
            busy_r <= 1'b1;
            div_r <= '0;
            us_r <= '0;
            pmode_r <= cmd_r;
            paddr_r <= base_r;
        end else if (busy_r) begin
            // Runs from the system clock only, serial clock may stop
            div_r <= tick ? '0 : div_r + 7'h01;
            us_r <= tick ? us_r + 24'h1 : us_r;
            busy_r <= !prog_done;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prot_addr_r <= eep_pkg::PROT_ADDR_RST;
            prot_clr_r <= eep_pkg::PROT_CLR_RST;
            lock_r <= 1'b0;
        end else if (prog_done) begin
            if (pmode_r == eep_pkg::C_PRWRITE) begin
                prot_addr_r <= paddr_r;
                prot_clr_r <= 1'b0;
            end else if (pmode_r == eep_pkg::C_PRCLEAR) begin
                prot_addr_r <= eep_pkg::PROT_ADDR_RST;
                prot_clr_r <= 1'b1;
            end else if (pmode_r == eep_pkg::C_PRDS) begin
                lock_r <= 1'b1;
            end
        end
    end

    // ==================================================
    // Array; old content simply replaced, no erase step
    logic [15:0] mem_r [eep_pkg::WORDS];
    logic [63:0] wr_hit;
    logic [63:0] prot_hit;

    for (genvar i = 0; i < eep_pkg::WORDS; i++) begin : g_mem
        localparam logic [5:0] IA = 6'(i);
        // Independent of the commit gate, so the check below sees a broken gate
        assign prot_hit[i] = !prot_clr_r && IA >= prot_addr_r;
        assign wr_hit[i] = pmode_r == eep_pkg::C_WRALL
            || ((pmode_r == eep_pkg::C_WRITE || pmode_r == eep_pkg::C_PAGE)
            && vld_r[IA[1:0]] && IA[5:2] == paddr_r[5:2]);
        always_ff @(posedge clock) begin
            if (prog_done && wr_hit[i]) begin
                mem_r[i] <= (pmode_r == eep_pkg::C_WRALL)
                          ? lat_r[paddr_r[1:0]] : lat_r[IA[1:0]];
            end
        end
    end

    // ==================================================
    // Data out: read stream and ready/busy
    logic [15:0] rd_sh_r;
    logic [5:0] ptr_r;
    logic [3:0] rcnt_r;
    logic show_rdy_r;
    logic rd_start;

    assign rd_start = hdr_done && (dec_cmd == eep_pkg::C_READ || dec_cmd == eep_pkg::C_PRREAD);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            show_rdy_r <= 1'b0;
        end else if (commit) begin
            show_rdy_r <= 1'b1;
        end else if (frame_start) begin
            show_rdy_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dout <= 1'b0;
            dout_oe_n <= 1'b1;
            rd_sh_r <= '0;
            ptr_r <= '0;
            rcnt_r <= '0;
        end else if (!p.cs) begin
            dout_oe_n <= 1'b1;
        end else if (rd_start) begin
            ptr_r <= full[5:0];
            rd_sh_r <= (dec_cmd == eep_pkg::C_PRREAD)
                     ? {2'h0, prot_addr_r, prot_clr_r, 7'h00} : mem_r[full[5:0]];
            dout <= 1'b0;
            dout_oe_n <= 1'b0;
            rcnt_r <= '0;
        end else if (state_r == eep_pkg::S_READ) begin
            dout_oe_n <= 1'b0;
            if (sck_rise) begin
                dout <= rd_sh_r[15];
                rcnt_r <= rcnt_r + 4'h1;
                rd_sh_r <= {rd_sh_r[14:0], 1'b0};
                if (rcnt_r == 4'hF) begin
                    ptr_r <= ptr_r + 6'h01;
                    rd_sh_r <= mem_r[ptr_r + 6'h01];
                end
            end
        end else if (state_r == eep_pkg::S_IDLE && show_rdy_r) begin
            dout <= !busy_r;
            dout_oe_n <= 1'b0;
        end else begin
            dout_oe_n <= 1'b1;
        end
    end

    // ==================================================
    // Checks
    a_hiz_cs_low: assert property (@(posedge clock) disable iff (sys_rst)
        !p.cs |=> dout_oe_n)
        else $error("data out driven with chip select low");
    a_busy_low_out: assert property (@(posedge clock) disable iff (sys_rst)
        busy_r && p.cs && state_r == eep_pkg::S_IDLE && show_rdy_r |=> !dout && !dout_oe_n)
        else $error("busy not shown as low");
    a_ready_high: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(busy_r) ##0 p.cs && $past(p.cs) && state_r == eep_pkg::S_IDLE |=> dout)
        else $error("ready not shown after programming");
    a_prog_hold: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(busy_r) |-> busy_r [*8])
        else $error("programming ended too early");
    a_ignore_busy: assert property (@(posedge clock) disable iff (sys_rst)
        busy_r |=> state_r == eep_pkg::S_IDLE)
        else $error("frame decoded while busy");
    a_ptr_wrap: assert property (@(posedge clock) disable iff (sys_rst)
        sck_rise && state_r == eep_pkg::S_READ && rcnt_r == 4'hF && ptr_r == 6'h3F
        && !busy_r |=> ptr_r == 6'h00)
        else $error("pointer did not wrap");
    a_ptr_step: assert property (@(posedge clock) disable iff (sys_rst)
        sck_rise && state_r == eep_pkg::S_READ && rcnt_r == 4'hF && !busy_r
        |=> ptr_r == $past(ptr_r) + 6'h01 && rd_sh_r == mem_r[ptr_r])
        else $error("pointer did not advance");
    a_dummy_zero: assert property (@(posedge clock) disable iff (sys_rst)
        rd_start && p.cs |=> !dout && !dout_oe_n && ptr_r == $past(full[5:0]))
        else $error("read start without dummy zero");
    a_lock_holds: assert property (@(posedge clock) disable iff (sys_rst)
        lock_r |=> lock_r && $stable(prot_addr_r) && $stable(prot_clr_r))
        else $error("protect register changed after lock");
    a_no_prot_wr: assert property (@(posedge clock) disable iff (sys_rst)
        prog_done |-> (wr_hit & prot_hit) == 64'h0)
        else $error("write landed in protected area");
endmodule : eep_dev

// *** design/eep_pkg.sv ***
package eep_pkg;
    // ==================================================
    // Array geometry
    localparam int WORDS = 64;
    localparam int AW = 6;
    localparam int DW = 16;
    localparam int PAGE_WORDS = 4;
    localparam int HDR_BITS = 8;
    localparam int PIN_COUNT = 5;
    localparam int FIFO_DEPTH = 2;

    // ==================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int PROG_TIME_MS = 10;
    localparam int PROG_US = PROG_TIME_MS * 1000;
    localparam int PROG_CYC = PROG_US * TICK_CYC;

    // ==================================================
    // Opcodes and address extensions
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_PAGE = 2'h3;
    localparam logic [1:0] EX_WDS = 2'h0;
    localparam logic [1:0] EX_WRALL = 2'h1;
    localparam logic [1:0] EX_WEN = 2'h3;
    localparam logic [5:0] ADDR_ONES = 6'h3F;
    localparam logic [5:0] ADDR_ZERO = 6'h00;

    // ==================================================
    // Reset values
    localparam logic [5:0] PROT_ADDR_RST = 6'h3F;
    localparam logic PROT_CLR_RST = 1'b1;

    typedef struct packed {
        logic cs;
        logic sck;
        logic din;
        logic wen;
        logic pren;
    } eep_pins_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } eep_word_t;

    typedef enum {
        C_NONE, C_READ, C_WRITE, C_PAGE, C_WRALL, C_WEN, C_WDS,
        C_PRREAD, C_PRWRITE, C_PRCLEAR, C_PREN, C_PRDS
    } eep_cmd_t;

    typedef enum {S_IDLE, S_HDR, S_DATA, S_READ, S_DONE} eep_state_t;
endpackage : eep_pkg

// *** design/eep_buf.sv ***
`timescale 1ns/100ps
module eep_buf #(
    parameter int W = 22,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] buf_r [DEPTH];
    logic [PW-1:0] wr_r;
    logic [PW-1:0] rd_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = cnt_r != (PW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data = buf_r[rd_r];

    always_ff @(posedge clock) begin
        if (push) begin
            buf_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        end
    end

    a_buf_bounded: assert property (@(posedge clock) disable iff (sys_rst)
        (cnt_r == (PW+1)'(DEPTH)) |-> ##1 !(cnt_r > (PW+1)'(DEPTH)))
        else $error("buffer count beyond depth");
endmodule : eep_buf

// *** test/eep_host.sv ***
`timescale 1ns/100ps
module eep_host (
    // Clock
    input wire logic clock,
    // Serial bus
    output logic cs,
    output logic sck,
    output logic din,
    input wire logic dout
);
    localparam int HALF = 26; // Phases above 250 ns each
    initial begin
        cs = 1'b0;
        sck = 1'b0;
        din = 1'b0;
    end
    // ==========
    // Bus cycles
    task automatic bit1(input logic b, output logic q);
        din <= b;
        repeat (HALF) @(posedge clock);
        sck <= 1'b1;
        repeat (HALF) @(posedge clock);
        q = dout;
        sck <= 1'b0;
    endtask : bit1
    task automatic start(input logic [1:0] op, input logic [5:0] a, output logic q);
        logic [8:0] h;
        h = {1'b1, op, a};
        cs <= 1'b1;
        for (int i = 8; i >= 0; i--) bit1(h[i], q);
    endtask : start
    task automatic word(input logic [15:0] w, output logic [15:0] r);
        for (int i = 15; i >= 0; i--) bit1(w[i], r[i]);
    endtask : word
    task automatic stop();
        cs <= 1'b0;
        repeat (2 * HALF) @(posedge clock);
    endtask : stop
    task automatic settle(output logic busy, output logic rdy);
        cs <= 1'b1;
        repeat (HALF) @(posedge clock);
        busy = dout;
        rdy = 1'b0;
        for (int n = 0; n < 3000 && !rdy; n++) begin
            @(posedge clock);
            rdy = (dout === 1'b1);
        end
        stop();
    endtask : settle
endmodule : eep_host

// *** test/eep_dev_tb.sv ***
`timescale 1ns/100ps
module eep_dev_tb;
    logic clock;
    logic sys_rst;
    logic wen_pin;
    logic pren_pin;
    logic cs;
    logic sck;
    logic din;
    logic dout;
    logic dout_oe_n;
    wire q_line;
    int fails;
    int samples_checked;
    assign q_line = (dout_oe_n === 1'b0) ? dout : 1'bz;
    // Short program cycle of 200 clocks
    eep_dev #(.PROG_TICKS(2)) i_eep_dev (.clock(clock), .sys_rst(sys_rst), .cs_pin(cs),
        .sck_pin(sck), .din_pin(din), .wen_pin(wen_pin), .pren_pin(pren_pin),
        .dout(dout), .dout_oe_n(dout_oe_n));
    eep_host i_eep_host (.clock(clock), .cs(cs), .sck(sck), .din(din), .dout(q_line));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ==========
    // Tasks
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic prog();
        logic b;
        logic r;
        i_eep_host.settle(b, r);
        chk("busy", 16'h0000, {15'h0000, b});
        chk("ready", 16'h0001, {15'h0000, r});
    endtask : prog
    task automatic cmd(input logic [1:0] op, input logic [5:0] a, input logic ok);
        logic q;
        i_eep_host.start(op, a, q);
        i_eep_host.stop();
        if (ok) prog();
    endtask : cmd
    task automatic wr(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
        input logic ok);
        logic q;
        logic [15:0] r;
        i_eep_host.start(op, a, q);
        i_eep_host.word(d, r);
        i_eep_host.stop();
        if (ok) prog();
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [15:0] e0, input logic [15:0] e1);
        logic q;
        logic [15:0] r;
        i_eep_host.start(eep_pkg::OP_READ, a, q);
        chk("dummy", 16'h0000, {15'h0000, q});
        i_eep_host.word(16'h0000, r);
        chk("word", e0, r);
        i_eep_host.word(16'h0000, r);
        chk("next word", e1, r);
        i_eep_host.stop();
        chk("release", 16'h0001, {15'h0000, dout_oe_n});
    endtask : rd
    task automatic t_basic();
        cmd(eep_pkg::OP_EXT, {eep_pkg::EX_WEN, 4'h0}, 1'b0);
        // Known background first, so every streamed word is defined
        wr(eep_pkg::OP_EXT, {eep_pkg::EX_WRALL, 4'h0}, 16'h0000, 1'b1);
        wr(eep_pkg::OP_WRITE, 6'h3F, 16'h1234, 1'b1);
        wr(eep_pkg::OP_WRITE, 6'h00, 16'h5678, 1'b1);
        rd(6'h3F, 16'h1234, 16'h5678);
    endtask : t_basic
    task automatic t_page();
        logic q;
        logic [15:0] r;
        i_eep_host.start(eep_pkg::OP_PAGE, 6'h05, q);
        for (int k = 0; k < 4; k++) i_eep_host.word(16'hA0A0 + 16'(k), r);
        i_eep_host.stop();
        prog();
        rd(6'h04, 16'hA0A3, 16'hA0A0);
        rd(6'h06, 16'hA0A1, 16'hA0A2);
    endtask : t_page
    task automatic t_wrall();
        wr(eep_pkg::OP_EXT, {eep_pkg::EX_WRALL, 4'h0}, 16'hC3C3, 1'b1);
        rd(6'h3F, 16'hC3C3, 16'hC3C3);
    endtask : t_wrall
    task automatic t_prot();
        logic q;
        logic [15:0] r;
        pren_pin <= 1'b1;
        cmd(eep_pkg::OP_EXT, {eep_pkg::EX_WEN, 4'h0}, 1'b0);
        cmd(eep_pkg::OP_WRITE, 6'h20, 1'b1);
        i_eep_host.start(eep_pkg::OP_READ, 6'h00, q);
        chk("protect dummy", 16'h0000, {15'h0000, q});
        i_eep_host.word(16'h0000, r);
        // Nine bits: two zeros, boundary address, cleared flag
        chk("protect register", 16'h0040, {7'h00, r[15:7]});
        i_eep_host.stop();
        pren_pin <= 1'b0;
        wr(eep_pkg::OP_WRITE, 6'h20, 16'h0F0F, 1'b0);
        wr(eep_pkg::OP_EXT, {eep_pkg::EX_WRALL, 4'h0}, 16'h0000, 1'b0);
        wr(eep_pkg::OP_WRITE, 6'h1F, 16'h1111, 1'b1);
        rd(6'h1F, 16'h1111, 16'hC3C3);
        pren_pin <= 1'b1;
        cmd(eep_pkg::OP_EXT, {eep_pkg::EX_WEN, 4'h0}, 1'b0);
        cmd(eep_pkg::OP_EXT, 6'h00, 1'b1);
        cmd(eep_pkg::OP_EXT, {eep_pkg::EX_WEN, 4'h0}, 1'b0);
        cmd(eep_pkg::OP_PAGE, 6'h3F, 1'b0);
        pren_pin <= 1'b0;
        wr(eep_pkg::OP_WRITE, 6'h20, 16'h2222, 1'b0);
        // Write strap low refuses an otherwise legal word
        wen_pin <= 1'b0;
        wr(eep_pkg::OP_WRITE, 6'h1F, 16'h4444, 1'b0);
        wen_pin <= 1'b1;
        cmd(eep_pkg::OP_EXT, {eep_pkg::EX_WDS, 4'h0}, 1'b0);
        wr(eep_pkg::OP_WRITE, 6'h1F, 16'h3333, 1'b0);
        rd(6'h1F, 16'h1111, 16'hC3C3);
    endtask : t_prot
    // ==========
    // Sequence
    initial begin
        sys_rst = 1'b1;
        wen_pin = 1'b1;
        pren_pin = 1'b0;
        fails = 0;
        samples_checked = 0;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clock);
        chk("idle release", 16'h0001, {15'h0000, dout_oe_n});
        t_basic();
        t_page();
        t_wrall();
        t_prot();
        finish_test();
    end
    initial begin
        repeat (90000) @(posedge clock);
        fails++;
        finish_test();
    end
endmodule : eep_dev_tb
